// *** hw/urx_rx_end.sv ***
// Purpose: receiver with majority voting, start-of-frame wake and address filter
// Assumes: wake outputs go to a power manager; tx_done comes from a local sender
// Notes:   one-word receive buffer; reading data pops it
// Contract
// R01: oversample 16 normal, 8 double speed
// R02: first vote sample 8 normal, 4 double
// R03: middle vote sample 9 normal, 5 double
// R04: accept five to ten data-plus-parity bits
// R05: far rate within 95.36 to 104.58 percent
// R06: start detector wakes from deep sleep
// R07: falling edge starts oscillator and port clock; in sync mode the code starts them on a bit clock rise with the line low
// R08: works async and sync, only when enabled
// R09: start irq at once when enabled
// R10: otherwise wake cpu at receive complete
// R11: sync rate limits on the far side
// R12: far error within +3.15 / -4.00 percent
// R13: filter drops non-address frames before buffer
// R14: filter mode leaves transmitter alone
// R15: stop bit or ninth bit gives frame type
// R16: type one is address, zero is data
// R17: master sets ninth bit for addresses
// R18: short frames need two stop bits
// R19: address frames set receive complete normally
// R20: filter bit shares transmit complete location
// R21: double speed divides 8 instead of 16
// R22: start rejected when two votes high
// R23: two-flop synchroniser on the serial pin
// R24: wake request holds until frame ends
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module urx_rx_end #(
  parameter int DIV_W = 12
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  urx_link_if.dev          link,
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        sleeping,
  input  wire logic        osc_stable,
  input  wire logic        tx_done,
  output logic             osc_enable,
  output logic             port_clk_enable,
  output logic             start_irq,
  output logic             cpu_wake
);
  if (DIV_W < 1 || DIV_W > 12) begin : g_chk
    $error("DIV_W must lie in 1..12");
  end

  typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} urx_rx_e;

  urx_rx_e          state;
  logic [15:0]      ctrl;
  logic [DIV_W-1:0] baud;
  logic [DIV_W-1:0] cnt;
  logic             filt, dbl, txc;
  logic             pin_s1, pin_s2, pin_d;
  logic             sck_s1, sck_s2, sck_d;
  logic [4:0]       samp, nsamp, spb, sf, sm;
  logic [3:0]       bit_idx, last_idx, clen;
  logic             v0, v1, maj;
  logic [10:0]      frame_bits;
  logic             frame_done;
  logic             rx_full, fe, dor, pe;
  logic [8:0]       rx_data;
  logic             wake_active;
  logic             fall, rise, start_seen, pop, store;
  logic [8:0]       dmask, data9;
  logic             pbit, stop_bit, ftype, perr;
  logic [15:0]      st;

  assign spb   = urx_pkg::samples_per_bit(dbl);  // R01 R21
  assign sf    = urx_pkg::first_vote(dbl);  // R02
  assign sm    = urx_pkg::mid_vote(dbl);  // R03
  assign nsamp = (samp == spb) ? 5'h01 : samp + 5'h01;
  assign clen  = urx_pkg::char_len(ctrl[urx_pkg::CT_CS +: 3]);
  // five to nine character bits plus optional parity
  assign last_idx = clen + {3'h0, ctrl[urx_pkg::CT_PEN]} + 4'h1;  // R04
  assign maj   = (v0 & v1) | (v0 & pin_s2) | (v1 & pin_s2);
  assign pop   = rd && addr == urx_pkg::REG_DATA;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_d  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d  <= 1'b0;
    end else begin
      pin_s1 <= link.serial_in_pin;  // R23
      pin_s2 <= pin_s1;  // R23
      pin_d  <= pin_s2;
      sck_s1 <= link.sync_clk;
      sck_s2 <= sck_s1;
      sck_d  <= sck_s2;
    end
  end

  assign fall = pin_d & ~pin_s2;
  assign rise = sck_s2 & ~sck_d;
  // start condition in either mode
  assign start_seen = (state == RX_IDLE) && (ctrl[urx_pkg::CT_SYNC] ?
                      (rise && !pin_s2) : fall);  // R08

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= urx_pkg::CTRL_RST;
      baud <= urx_pkg::BAUD_RST[DIV_W-1:0];
      filt <= 1'b0;
      dbl  <= 1'b0;
    end else if (wr && addr == urx_pkg::REG_CTRL) begin
      ctrl <= wdata;
    end else if (wr && addr == urx_pkg::REG_BAUD) begin
      baud <= wdata[DIV_W-1:0];
    end else if (wr && addr == urx_pkg::REG_STATUS) begin
      filt <= wdata[urx_pkg::ST_FILT];  // R20
      dbl  <= wdata[urx_pkg::ST_DBL];
    end
  end

  // transmit complete shares the status word; the filter never touches it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txc <= 1'b0;
    end else if (tx_done) begin
      txc <= 1'b1;  // R14
    end else if (wr && addr == urx_pkg::REG_STATUS && wdata[urx_pkg::ST_TXC]) begin
      txc <= 1'b0;  // R20
    end
  end

  // ----------------------------------------------------------------
  // frame receiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= RX_IDLE;
      cnt        <= '0;
      samp       <= 5'h01;
      bit_idx    <= 4'h0;
      v0         <= 1'b1;
      v1         <= 1'b1;
      frame_bits <= 11'h7FF;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      unique case (state)
        RX_IDLE: begin
          if (start_seen && ctrl[urx_pkg::CT_SYNC]) begin
            state   <= RX_SYNC;
            bit_idx <= 4'h1;
          end else if (start_seen) begin
            state   <= RX_ASYNC;
            samp    <= 5'h01;  // first low sample
            cnt     <= baud;
            bit_idx <= 4'h0;
          end
        end
        RX_ASYNC: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            cnt  <= baud;
            samp <= nsamp;
            if (nsamp == sf) begin
              v0 <= pin_s2;  // R02
            end
            if (nsamp == sm) begin
              v1 <= pin_s2;  // R03
            end
            if (nsamp == sf + 5'h02) begin
              if (bit_idx == 4'h0 && maj) begin
                state <= RX_IDLE;  // R22
              end else if (bit_idx != 4'h0) begin
                frame_bits[bit_idx - 4'h1] <= maj;
                if (bit_idx == last_idx) begin
                  state      <= RX_IDLE;  // next start may follow at once
                  frame_done <= 1'b1;
                end
              end
            end
            if (nsamp == 5'h01) begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        RX_SYNC: begin
          if (rise) begin
            frame_bits[bit_idx - 4'h1] <= pin_s2;
            if (bit_idx == last_idx) begin
              state      <= RX_IDLE;
              frame_done <= 1'b1;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        default: state <= RX_IDLE;
      endcase
    end
  end

  // frame decode: data, parity check and frame type
  always_comb begin
    dmask    = 9'h1FF >> (4'h9 - clen);
    data9    = frame_bits[8:0] & dmask;
    pbit     = frame_bits[clen];
    stop_bit = frame_bits[clen + {3'h0, ctrl[urx_pkg::CT_PEN]}];
    perr     = ctrl[urx_pkg::CT_PEN] & (^data9 ^ pbit ^ ctrl[urx_pkg::CT_PODD]);
    ftype    = (clen == urx_pkg::CHAR_MAX) ? data9[urx_pkg::DATA9] : stop_bit;  // R15
    // data frames are dropped while the filter is on
    store    = frame_done && (!filt || ftype);  // R13 R16
  end

  // ----------------------------------------------------------------
  // receive buffer and its flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_full <= 1'b0;
      rx_data <= 9'h000;
      fe      <= 1'b0;
      pe      <= 1'b0;
      dor     <= 1'b0;
    end else if (store && (!rx_full || pop)) begin
      rx_full <= 1'b1;  // R19
      rx_data <= data9;
      fe      <= ~stop_bit;
      pe      <= perr;
      dor     <= 1'b0;
    end else if (store) begin
      dor <= 1'b1;  // buffer full, new frame lost
    end else if (pop) begin
      rx_full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // start-of-frame wake and interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_active <= 1'b0;
      start_irq   <= 1'b0;
      cpu_wake    <= 1'b0;
    end else begin
      if (sleeping && ctrl[urx_pkg::CT_SFD] && start_seen) begin
        wake_active <= 1'b1;  // R06 R07 R08
      end else if (frame_done || (state == RX_IDLE && (osc_stable || !sleeping))) begin
        wake_active <= 1'b0;  // R24
      end
      start_irq <= ctrl[urx_pkg::CT_SFD] && ctrl[urx_pkg::CT_SIE] && start_seen;  // R09
      cpu_wake  <= sleeping && (ctrl[urx_pkg::CT_SIE] ?
                   (ctrl[urx_pkg::CT_SFD] && start_seen) : store);  // R10
    end
  end

  assign osc_enable      = wake_active;  // R07
  assign port_clk_enable = wake_active;  // R07

  // status word layout
  always_comb begin
    st                  = 16'h0000;
    st[urx_pkg::ST_RXC]  = rx_full;
    st[urx_pkg::ST_TXC]  = txc;
    st[urx_pkg::ST_FE]   = fe;
    st[urx_pkg::ST_DOR]  = dor;
    st[urx_pkg::ST_PE]   = pe;
    st[urx_pkg::ST_DBL]  = dbl;
    st[urx_pkg::ST_FILT] = filt;  // R20
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (!rd) begin
      rdata <= 16'h0000;
    end else begin
      unique case (addr)
        urx_pkg::REG_STATUS: rdata <= st;
        urx_pkg::REG_CTRL:   rdata <= ctrl;
        urx_pkg::REG_BAUD:   rdata <= {{(16-DIV_W){1'b0}}, baud};
        urx_pkg::REG_DATA:   rdata <= {7'h00, rx_data};
      endcase
    end
  end
endmodule : urx_rx_end
`default_nettype wire

// *** hw/urx_pkg.sv ***
// Purpose: shared constants and helpers for the serial receive link
// Assumes: both ends use the same register layout for control fields
// Notes:   sample numbers count from 1 at the first low sample
package urx_pkg;
  // ----------------------------------------------------------------
  // register offsets on the plain register port
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CTRL   = 2'h1;
  localparam logic [1:0] REG_BAUD   = 2'h2;
  localparam logic [1:0] REG_DATA   = 2'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_RXC   = 7;  // receive complete
  localparam int ST_TXC   = 6;  // transmit complete, write one to clear
  localparam int ST_FE    = 4;
  localparam int ST_DOR   = 3;
  localparam int ST_PE    = 2;
  localparam int ST_DBL   = 1;  // double speed select
  localparam int ST_FILT  = 0;  // address filter mode
  localparam int ST_BUSY  = 0;  // transmitter end
  localparam int ST_DONE  = 1;  // transmitter end, write one to clear
  localparam int CT_SYNC  = 0;
  localparam int CT_PEN   = 1;
  localparam int CT_PODD  = 2;
  localparam int CT_CS    = 3;  // three-bit character size code
  localparam int CT_SFD   = 6;  // receiver: start detect enable
  localparam int CT_STOP2 = 6;  // transmitter: two stop bits
  localparam int CT_SIE   = 7;  // receiver: start irq enable
  localparam int CT_DBL   = 8;  // transmitter: double speed
  localparam int DATA9    = 8;  // ninth bit / address marker

  // ----------------------------------------------------------------
  // reset values and sampling figures
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0018;  // eight-bit characters
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [4:0]  S_NORM   = 5'h10;
  localparam logic [4:0]  S_DBL    = 5'h08;
  localparam logic [4:0]  SF_NORM  = 5'h08;
  localparam logic [4:0]  SF_DBL   = 5'h04;
  localparam logic [4:0]  SM_NORM  = 5'h09;
  localparam logic [4:0]  SM_DBL   = 5'h05;
  localparam logic [3:0]  CHAR_MIN = 4'h5;
  localparam logic [3:0]  CHAR_MAX = 4'h9;

  // samples per bit period
  function automatic logic [4:0] samples_per_bit(input logic dbl);
    return dbl ? S_DBL : S_NORM;
  endfunction : samples_per_bit

  // first of the three voting samples
  function automatic logic [4:0] first_vote(input logic dbl);
    return dbl ? SF_DBL : SF_NORM;
  endfunction : first_vote

  // middle voting sample
  function automatic logic [4:0] mid_vote(input logic dbl);
    return dbl ? SM_DBL : SM_NORM;
  endfunction : mid_vote

  // character length from size code, clipped to the longest form
  function automatic logic [3:0] char_len(input logic [2:0] code);
    logic [3:0] n;
    n = CHAR_MIN + {1'b0, code};
    return (n > CHAR_MAX) ? CHAR_MAX : n;
  endfunction : char_len
endpackage : urx_pkg

// *** hw/urx_link_if.sv ***
// Purpose: serial line between remote transmitter and receiving device
// Assumes: one clock domain on both ends, line idles high
// Notes:   sync_clk only toggles in synchronous mode
`timescale 1ns/100ps
`default_nettype none
interface urx_link_if;
  logic serial_in_pin;  // data line, idle high
  logic sync_clk;       // bit clock in synchronous mode

  modport dev  (input  serial_in_pin, input  sync_clk);
  modport host (output serial_in_pin, output sync_clk);
endinterface : urx_link_if
`default_nettype wire

// *** hw/urx_tx_end.sv ***
// Purpose: remote transmitter end driving the serial line
// Assumes: same baud divisor and oversampling arithmetic as the receiver
// Notes:   a data write while busy is dropped
`timescale 1ns/100ps
`default_nettype none
module urx_tx_end (
  input  wire logic        clk,
  input  wire logic        reset_n,
  urx_link_if.host         link,
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             frame_done
);
  typedef enum logic {TX_IDLE, TX_SEND} urx_tx_e;

  urx_tx_e     state;
  logic [15:0] ctrl;
  logic [11:0] baud;
  logic [11:0] cnt;
  logic [4:0]  samp;
  logic [3:0]  bit_idx;
  logic [3:0]  last_idx;
  logic [11:0] frame;
  logic        done;
  logic [4:0]  spb;
  logic [4:0]  nsamp;
  logic [3:0]  clen;

  assign spb   = urx_pkg::samples_per_bit(ctrl[urx_pkg::CT_DBL]);
  assign nsamp = (samp == spb) ? 5'h01 : samp + 5'h01;
  assign clen  = urx_pkg::char_len(ctrl[urx_pkg::CT_CS +: 3]);

  // start, data lsb first, optional parity, then stop bits
  function automatic logic [11:0] build(input logic [8:0] d,
                                        input logic [3:0] n,
                                        input logic       pen,
                                        input logic       podd);
    logic [11:0] f;
    logic [8:0]  m;
    m = 9'h1FF >> (4'h9 - n);
    f = 12'hFFF;
    f[9:1] = (d & m) | ~m;
    f[0] = 1'b0;
    if (pen) begin
      f[n + 4'h1] = ^(d & m) ^ podd;
    end
    return f;
  endfunction : build

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= urx_pkg::CTRL_RST;
      baud <= urx_pkg::BAUD_RST;
    end else if (wr && addr == urx_pkg::REG_CTRL) begin
      ctrl <= wdata;
    end else if (wr && addr == urx_pkg::REG_BAUD) begin
      baud <= wdata[11:0];
    end
  end

  // frame sequencer; bit period is (divisor + 1) * samples clocks
  always_ff @(posedge clk or negedge reset_n) begin  // R05
    if (!reset_n) begin
      state              <= TX_IDLE;
      link.serial_in_pin <= 1'b1;
      link.sync_clk      <= 1'b0;
      cnt                <= 12'h000;
      samp               <= 5'h01;
      bit_idx            <= 4'h0;
      last_idx           <= 4'h0;
      frame              <= 12'hFFF;
      frame_done         <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      unique case (state)
        TX_IDLE: begin
          link.sync_clk <= 1'b0;
          if (wr && addr == urx_pkg::REG_DATA) begin
            // ninth bit carries the address marker in nine-bit form
            frame <= build(wdata[urx_pkg::DATA9:0], clen, ctrl[urx_pkg::CT_PEN],
                           ctrl[urx_pkg::CT_PODD]);  // R17
            // a second stop bit keeps the frame-type bit clear of the next start
            last_idx <= clen + {3'h0, ctrl[urx_pkg::CT_PEN]} + 4'h1
                        + {3'h0, ctrl[urx_pkg::CT_STOP2]};  // R18
            link.serial_in_pin <= 1'b0;
            bit_idx <= 4'h0;
            samp    <= 5'h01;
            cnt     <= baud;
            state   <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (cnt != 12'h000) begin
            cnt <= cnt - 12'h001;
          end else begin
            cnt  <= baud;
            samp <= nsamp;
            // rising edge of the bit clock in the middle of each bit
            link.sync_clk <= ctrl[urx_pkg::CT_SYNC] && (nsamp > (spb >> 1));  // R11
            if (samp == spb) begin
              if (bit_idx == last_idx) begin
                state              <= TX_IDLE;
                link.serial_in_pin <= 1'b1;
                frame_done         <= 1'b1;
              end else begin
                bit_idx            <= bit_idx + 4'h1;
                // the last stop of the longest frame lies past the frame word
                link.serial_in_pin <= (bit_idx == 4'hB) || frame[bit_idx + 4'h1];
              end
            end
          end
        end
      endcase
    end
  end

  // sticky done flag, set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else if (frame_done) begin
      done <= 1'b1;
    end else if (wr && addr == urx_pkg::REG_STATUS && wdata[urx_pkg::ST_DONE]) begin
      done <= 1'b0;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (!rd) begin
      rdata <= 16'h0000;
    end else begin
      unique case (addr)
        urx_pkg::REG_STATUS: rdata <= {14'h0000, done, state == TX_SEND};
        urx_pkg::REG_CTRL:   rdata <= ctrl;
        urx_pkg::REG_BAUD:   rdata <= {4'h0, baud};
        urx_pkg::REG_DATA:   rdata <= 16'h0000;
      endcase
    end
  end
endmodule : urx_tx_end
`default_nettype wire

// *** dv/urx_link_monitor.sv ***
// Purpose: link and wake checks beside the serial link
// Assumes: asynchronous framing only, one clock
// Notes:   sees the link lines and the wake outputs
`timescale 1ns/100ps
`default_nettype none
module urx_link_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_in_pin,
  input wire logic sync_clk,
  input wire logic sleeping,
  input wire logic osc_enable,
  input wire logic port_clk_enable,
  input wire logic start_irq,
  input wire logic cpu_wake
);
  // ------------------------------------------------------------
  // wake and link properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_irq_one_pulse: assert property (start_irq |=> !start_irq)
    else $error("start irq longer than one cycle");
  a_irq_at_start: assert property (start_irq |-> !$past(serial_in_pin, 2))
    else $error("start irq without a low line");
  a_wake_one_pulse: assert property (cpu_wake |=> !cpu_wake)
    else $error("cpu wake longer than one cycle");
  a_osc_after_fall: assert property ($rose(osc_enable) |->
    !$past(serial_in_pin, 1) && $past(serial_in_pin, 6))
    else $error("oscillator started without a line fall");
  a_osc_needs_sleep: assert property ($rose(osc_enable) |-> $past(sleeping))
    else $error("oscillator started while awake");
  a_clocks_paired: assert property (port_clk_enable == osc_enable)
    else $error("port clock and oscillator enables differ");
  a_osc_holds_frame: assert property (osc_enable && !serial_in_pin |=> osc_enable)
    else $error("oscillator dropped mid frame");
  a_irq_with_osc: assert property (start_irq && sleeping |-> osc_enable)
    else $error("start irq while oscillator off");
  a_sck_quiet: assert property (!sync_clk)
    else $error("bit clock moved in asynchronous mode");

  // main scenarios reached
  c_osc_rise: cover property ($rose(osc_enable));
  c_irq: cover property (start_irq);
  c_wake: cover property (cpu_wake);
endmodule : urx_link_monitor
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: both link ends joined, driven over their register ports
// Assumes: divisor 1 on both ends, asynchronous frames
// Notes:   each scenario judges its own results
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic        clk, reset_n, sleeping, osc_stable, tx_done, osc_q;
  logic [1:0]  h_addr, d_addr;
  logic [15:0] h_wdata, d_wdata, h_rdata, d_rdata, q;
  logic        h_wr, h_rd, d_wr, d_rd, frame_done;
  logic        osc_enable, port_clk_enable, start_irq, cpu_wake;
  int          failures, comparisons, n_irq, n_wake, n_osc;

  urx_link_if urx_link_if_inst ();
  urx_tx_end urx_tx_end_inst (.clk(clk), .reset_n(reset_n), .link(urx_link_if_inst.host),
    .addr(h_addr), .wdata(h_wdata), .wr(h_wr), .rd(h_rd), .rdata(h_rdata),
    .frame_done(frame_done));
  urx_rx_end #(.DIV_W(12)) urx_rx_end_inst (.clk(clk), .reset_n(reset_n),
    .link(urx_link_if_inst.dev), .addr(d_addr), .wdata(d_wdata), .wr(d_wr), .rd(d_rd),
    .rdata(d_rdata), .sleeping(sleeping), .osc_stable(osc_stable), .tx_done(tx_done),
    .osc_enable(osc_enable), .port_clk_enable(port_clk_enable), .start_irq(start_irq),
    .cpu_wake(cpu_wake));
  urx_link_monitor urx_link_monitor_inst (.clk(clk), .reset_n(reset_n),
    .serial_in_pin(urx_link_if_inst.serial_in_pin), .sync_clk(urx_link_if_inst.sync_clk),
    .sleeping(sleeping), .osc_enable(osc_enable), .port_clk_enable(port_clk_enable),
    .start_irq(start_irq), .cpu_wake(cpu_wake));

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // pulse and wake counters
  always @(posedge clk) begin
    osc_q <= osc_enable;
    if (start_irq) n_irq++;
    if (cpu_wake) n_wake++;
    if (osc_enable && !osc_q) n_osc++;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one write or read; read data lands in q
  task automatic bus(input bit dev, input bit w, input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    if (dev) {d_addr, d_wdata, d_wr, d_rd} <= {a, d, w, !w};
    else {h_addr, h_wdata, h_wr, h_rd} <= {a, d, w, !w};
    @(posedge clk);
    {d_wr, d_rd, h_wr, h_rd} <= 4'h0;
    #1 q = dev ? d_rdata : h_rdata;
  endtask : bus

  // host sends one frame, bounded wait for its end
  task automatic send(input logic [15:0] hctrl, input logic [15:0] d);
    bus(0, 1, urx_pkg::REG_CTRL, hctrl);
    bus(0, 1, urx_pkg::REG_DATA, d);
    for (int i = 0; i < 2000 && !frame_done; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (4) @(posedge clk);
    // sender idle with done set, also catches a frame that never ended
    bus(0, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q, 16'h0002);
    bus(0, 1, urx_pkg::REG_STATUS, 16'h0002);
  endtask : send

  // complete flag, data, then flag cleared
  task automatic recv(input logic [15:0] exp);
    bus(1, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q & 16'h0080, 16'h0080);
    bus(1, 0, urx_pkg::REG_DATA, 16'h0000);
    check(q, exp);
    bus(1, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q & 16'h0080, 16'h0000);
  endtask : recv

  task automatic report_and_stop();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    bus(1, 0, urx_pkg::REG_CTRL, 16'h0000);
    check(q, urx_pkg::CTRL_RST);
    bus(1, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q, 16'h0000);
  endtask : s_reset

  // size codes 0 to 5, five to nine bits
  task automatic s_sizes();
    logic [15:0] d, m, c;
    for (int k = 0; k < 6; k++) begin
      c = {10'h000, 3'(k), 3'h0};
      d = 16'h01A5 ^ 16'(k);
      m = (16'h0001 << ((k > 4) ? 9 : 5 + k)) - 16'h0001;
      bus(1, 1, urx_pkg::REG_CTRL, c);
      send(c, d);
      recv(d & m);
    end
    // ten-bit body: nine bits plus parity, sender even and receiver odd
    bus(1, 1, urx_pkg::REG_CTRL, 16'h0026);
    send(16'h0022, 16'h0155);
    bus(1, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q, 16'h0084);
    bus(1, 0, urx_pkg::REG_DATA, 16'h0000);
    check(q, 16'h0155);
  endtask : s_sizes

  task automatic s_double();
    bus(1, 1, urx_pkg::REG_STATUS, 16'h0002);
    bus(1, 1, urx_pkg::REG_CTRL, 16'h0018);
    send(16'h0118, 16'h005A);
    recv(16'h005A);
    bus(1, 1, urx_pkg::REG_STATUS, 16'h0000);
  endtask : s_double

  task automatic s_filter();
    bus(1, 1, urx_pkg::REG_STATUS, 16'h0001);
    bus(1, 1, urx_pkg::REG_CTRL, 16'h0020);
    send(16'h0020, 16'h0033);
    bus(1, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q, 16'h0001);
    send(16'h0020, 16'h0142);
    recv(16'h0142);
    bus(1, 1, urx_pkg::REG_CTRL, 16'h0018);
    send(16'h0020, 16'h0077);
    bus(1, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q, 16'h0001);
    send(16'h0020, 16'h0166);
    recv(16'h0066);
    send(16'h0058, 16'h0011);
    recv(16'h0011);
    @(posedge clk) tx_done <= 1'b1;
    @(posedge clk) tx_done <= 1'b0;
    bus(1, 1, urx_pkg::REG_STATUS, 16'h0000);
    bus(1, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q, 16'h0040);
    bus(1, 1, urx_pkg::REG_STATUS, 16'h0040);
    bus(1, 0, urx_pkg::REG_STATUS, 16'h0000);
    check(q, 16'h0000);
  endtask : s_filter

  // asleep: detector off, on without irq, on with irq
  task automatic s_wake();
    logic [15:0] ctl [3] = '{16'h0018, 16'h0058, 16'h00D8};
    sleeping <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      bus(1, 1, urx_pkg::REG_CTRL, ctl[k]);
      {n_irq, n_wake, n_osc} = {32'd0, 32'd0, 32'd0};
      send(16'h0018, 16'h0081);
      check(16'(n_osc), (k > 0) ? 16'h0001 : 16'h0000);
      check(16'(n_irq), (k > 1) ? 16'h0001 : 16'h0000);
      check(16'(n_wake), 16'h0001);
      check({15'h0000, osc_enable}, 16'h0000);
      recv(16'h0081);
    end
    sleeping <= 1'b0;
  endtask : s_wake

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {reset_n, sleeping, osc_stable, tx_done, h_wr, h_rd, d_wr, d_rd} = 8'h00;
    {h_addr, d_addr, h_wdata, d_wdata} = 36'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    s_reset();
    bus(0, 1, urx_pkg::REG_BAUD, 16'h0001);
    bus(1, 1, urx_pkg::REG_BAUD, 16'h0001);
    s_sizes();
    s_double();
    s_filter();
    s_wake();
    report_and_stop();
  end

  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
